// file: safd_map.vh
`ifndef SAFD_MAP_VH
`define SAFD_MAP_VH
// Register indices; byte address is four times the index
`define SAFD_IDX_CTRL2 6'h05
`define SAFD_IDX_CTRL1 6'h04
`define SAFD_IDX_STATUS 6'h06
`define SAFD_ADDR_CTRL2 8'h14
`define SAFD_ADDR_CTRL1 8'h10
`define SAFD_ADDR_STATUS 8'h18
`define SAFD_CTRL2_RESET 8'h08
`define SAFD_CTRL1_RESET 8'h00
// Control two fields
`define SAFD_BIT_DRIVE 6
`define SAFD_BIT_AUTO 5
`define SAFD_BIT_MULTI 4
// Control one fields
`define SAFD_BIT_STYLE 3
`define SAFD_BIT_FORMAT 2
`define SAFD_BIT_MODE 1
// Resulting configuration codes
`define SAFD_CFG_STEREO 2'h0
`define SAFD_CFG_TDM 2'h1
`define SAFD_CFG_MULTI 2'h2
// Repeat count a candidate must reach; the next matching frame then takes the detected mode
`define SAFD_STABLE_FRAMES 2'd2
`endif

// file: safd_sync.v
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for one pin level
module safd_sync (
  input wire clock,
  input wire rst,
  input wire enable,
  input wire async_in,
  output reg sync_out
);
  reg stage_one;

  // First stage feeds only the second
  always @(posedge clock) begin
    if (rst) begin
      stage_one <= 1'b0;
      sync_out <= 1'b0;
    end else if (enable) begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // safd_sync
`default_nettype wire

// file: safd_edge.v
`timescale 1ns/1ps
`default_nettype none
// Rising edge finder on a synchronised level
module safd_edge (
  input wire clock,
  input wire rst,
  input wire enable,
  input wire level,
  output wire rise
);
  reg last;

  always @(posedge clock) begin
    if (rst) begin
      last <= 1'b0;
    end else if (enable) begin
      last <= level;
    end
  end

  assign rise = enable & level & ~last;
endmodule // safd_edge
`default_nettype wire

// file: safd_top.v
`timescale 1ns/1ps
`default_nettype none
`include "safd_map.vh"
// How it works
// - Bit six picks sense pin drive strength
// - Auto enable makes format follow pin wiring
// - Normal wiring, pulsed sync gives TDM
// - Normal wiring, half duty gives multichip
// - Swapped pins give plain two-channel stereo
// - Auto mode ignores mode and format fields
// - Auto off uses mode, format, multichip fields
// - Multichip enable overrides interface mode field
// - Mode field zero stereo, one TDM
// - Format zero delayed, one left justified
// - Sync pulse or half duty; level marks left
module safd_top #(
  parameter CNT_W = 10
) (
  input wire clock,
  input wire rst,
  input wire clock_enable,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire bit_clock_pin,
  input wire frame_sync_pin,
  output reg output_drive_strength_sel,
  output reg [1:0] active_config,
  output reg active_data_delay,
  output reg active_left_high
);
  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] serial_audio_control_two;
  reg [7:0] serial_audio_control_one;
  // Field decode.
  // Control two: bit 6 drive, bit 5 auto, bit 4 multichip; the rest
  // are stored as written and have no effect in this block.
  // Control one keeps only mode, format and sync style; its other
  // bits belong to neighbouring blocks and read back as zero.
  wire format_autodetect_enable = serial_audio_control_two[`SAFD_BIT_AUTO];
  wire multichip_stereo_enable = serial_audio_control_two[`SAFD_BIT_MULTI];
  wire interface_mode_sel = serial_audio_control_one[`SAFD_BIT_MODE];
  wire data_format_sel = serial_audio_control_one[`SAFD_BIT_FORMAT];
  wire frame_sync_style_sel = serial_audio_control_one[`SAFD_BIT_STYLE];

  // ****************************************
  // Pin sampling
  // ****************************************
  // Both pins come from the host's clock domain, so each passes two
  // flops before anything reads it. Edges are therefore seen about
  // three clocks late, which only delays detection.
  wire bclk_s;
  wire fs_s;
  wire bclk_rise;
  wire fs_rise;

  safd_sync u_sync_bclk (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .async_in(bit_clock_pin),
    .sync_out(bclk_s)
  );

  safd_sync u_sync_fs (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .async_in(frame_sync_pin),
    .sync_out(fs_s)
  );

  // Rising edges only; the falling edges carry no frame information
  safd_edge u_edge_bclk (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .level(bclk_s),
    .rise(bclk_rise)
  );

  safd_edge u_edge_fs (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .level(fs_s),
    .rise(fs_rise)
  );

  // ****************************************
  // Frame measurement
  // ****************************************
  // Count bit clocks per frame and how many see sync high.
  // On swapped wiring the true bit clock lands on the sync pin,
  // so the sync pin toggles far more often than the clock pin.
  reg [CNT_W-1:0] bclk_count;
  reg [CNT_W-1:0] high_count;
  reg [1:0] candidate;
  reg [1:0] stable_count;
  reg [1:0] detected;
  reg [1:0] next_class;

  // ****************************************
  // Frame classification
  // ****************************************
  // Constants at counter width, the margin one bit wider like the limit, so no compare pads silently
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] CNT_FULL = {CNT_W{1'b1}};
  localparam [CNT_W-1:0] MIN_CLOCKS = {{(CNT_W-3){1'b0}}, 3'd4};
  localparam [CNT_W:0] PULSE_MARGIN = {{(CNT_W-1){1'b0}}, 2'd2};
  // Twice the high count against the frame length less a margin;
  // the margin keeps a half duty sync that loses one edge to
  // sampling from being read as a pulse.
  wire [CNT_W:0] high_twice = {high_count, 1'b0};
  wire [CNT_W:0] pulse_limit = {1'b0, bclk_count} - PULSE_MARGIN;
  wire too_few_clocks = (bclk_count < MIN_CLOCKS);
  wire pulsed_sync = (high_twice < pulse_limit);

  // Class of the frame just ended; the limit is only used when the
  // frame holds enough clocks, so it never wraps below zero
  always @* begin
    if (too_few_clocks) begin
      // Real clock sits on the sync pin: the wires are crossed
      next_class = `SAFD_CFG_STEREO;
    end else if (pulsed_sync) begin
      next_class = `SAFD_CFG_TDM;
    end else begin
      next_class = `SAFD_CFG_MULTI;
    end
  end

  // Frame boundary at sync rise; count bit clock edges between.
  // Both counters saturate so a stalled sync pin cannot wrap them
  // back into a legal looking frame.
  always @(posedge clock) begin
    if (rst) begin
      bclk_count <= {CNT_W{1'b0}};
      high_count <= {CNT_W{1'b0}};
    end else if (clock_enable) begin
      if (fs_rise) begin
        bclk_count <= {CNT_W{1'b0}};
        high_count <= {CNT_W{1'b0}};
      end else if (bclk_rise) begin
        if (bclk_count != CNT_FULL) begin
          bclk_count <= bclk_count + CNT_ONE;
        end
        if (fs_s && high_count != CNT_FULL) begin
          high_count <= high_count + CNT_ONE;
        end
      end
    end
  end

  // ****************************************
  // Detected mode hold
  // ****************************************
  // Mode is only taken after repeated identical frames, so a host
  // that is still starting its clocks cannot flip the interface.
  // The price is a few frames of delay after every real change.
  always @(posedge clock) begin
    if (rst) begin
      candidate <= `SAFD_CFG_STEREO;
      stable_count <= 2'd0;
      detected <= `SAFD_CFG_STEREO;
    end else if (clock_enable && fs_rise) begin
      if (next_class == candidate) begin
        if (stable_count == `SAFD_STABLE_FRAMES) begin
          detected <= candidate;
        end else begin
          stable_count <= stable_count + 2'd1;
        end
      end else begin
        candidate <= next_class;
        stable_count <= 2'd0;
      end
    end
  end

  // ****************************************
  // Configuration select
  // ****************************************
  reg [1:0] next_config;
  reg next_delay;
  reg next_left_high;
  reg [1:0] manual_config;

  // Software choice; the multichip enable outranks the mode field
  always @* begin
    case ({multichip_stereo_enable, interface_mode_sel})
      2'b00: begin
        manual_config = `SAFD_CFG_STEREO;
      end
      2'b01: begin
        manual_config = `SAFD_CFG_TDM;
      end
      2'b10, 2'b11: begin
        manual_config = `SAFD_CFG_MULTI;
      end
      default: begin
        manual_config = `SAFD_CFG_STEREO;
      end
    endcase
  end

  // Auto detection takes over config and delay when enabled; left high follows the sync style field, but in auto mode a detected multichip forces it high
  always @* begin
    if (format_autodetect_enable) begin
      // Software mode and format ignored here; every detected mode
      // uses the delayed timing
      next_config = detected;
      next_delay = 1'b1;
      next_left_high = (detected == `SAFD_CFG_MULTI) | frame_sync_style_sel;
    end else begin
      next_config = manual_config;
      next_delay = ~data_format_sel;
      next_left_high = frame_sync_style_sel;
    end
  end

  // All configuration outputs are registered together so a mode
  // change never shows a mix of old and new fields downstream
  always @(posedge clock) begin
    if (rst) begin
      active_config <= `SAFD_CFG_STEREO;
      active_data_delay <= 1'b1;
      active_left_high <= 1'b0;
      output_drive_strength_sel <= 1'b0;
    end else if (clock_enable) begin
      active_config <= next_config;
      active_data_delay <= next_delay;
      active_left_high <= next_left_high;
      output_drive_strength_sel <= serial_audio_control_two[`SAFD_BIT_DRIVE];
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state: pready rises in the second access cycle
  // The wait gives the read mux a full cycle after address setup
  wire hit_ctrl2 = (paddr == `SAFD_ADDR_CTRL2);
  wire hit_ctrl1 = (paddr == `SAFD_ADDR_CTRL1);
  wire hit_stat = (paddr == `SAFD_ADDR_STATUS);
  wire mapped = hit_ctrl2 | hit_ctrl1 | hit_stat;
  wire access = psel & penable & ~pready;
  // Writes commit on the edge where the master sees pready, so the
  // register changes on the very edge the transfer completes
  wire commit = psel & penable & pready;
  wire write_ctrl2 = commit & pwrite & hit_ctrl2;
  wire write_ctrl1 = commit & pwrite & hit_ctrl1;
  reg [31:0] next_rdata;

  // Read mux; unmapped offsets read zero and flag an error
  always @* begin
    if (hit_ctrl2) begin
      next_rdata = {24'h000000, serial_audio_control_two};
    end else if (hit_ctrl1) begin
      next_rdata = {24'h000000, serial_audio_control_one};
    end else if (hit_stat) begin
      next_rdata = {28'h0000000, detected, active_config};
    end else begin
      next_rdata = 32'h00000000;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      serial_audio_control_two <= `SAFD_CTRL2_RESET;
      serial_audio_control_one <= `SAFD_CTRL1_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clock_enable) begin
      // Response follows every access by one cycle
      pready <= access;
      pslverr <= access & ~mapped;
      if (access) begin
        prdata <= pwrite ? 32'h00000000 : next_rdata;
      end else begin
        prdata <= 32'h00000000;
      end
      if (write_ctrl2) begin
        serial_audio_control_two <= pwdata[7:0];
      end
      if (write_ctrl1) begin
        // Only mode, format and sync style are kept
        serial_audio_control_one <= {4'h0, pwdata[3:1], 1'b0};
      end
    end
  end
endmodule // safd_top
`default_nettype wire

// file: safd_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module safd_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_drive_strength_sel,
  input wire logic [1:0] active_config,
  input wire logic active_data_delay,
  input wire logic active_left_high
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [1:0] c2;
  // Shadow of auto and multichip bits, since the checker cannot see registers
  always @(posedge clock) begin
    if (rst) c2 <= 2'h0;
    else if (pready && pwrite && paddr == 8'h14) c2 <= pwdata[5:4];
  end
  sequence s_wr(a);
    pready && pwrite && paddr == a;
  endsequence
  property p_wait; psel && penable && !pready && clock_enable |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_freeze;
    !clock_enable |=> $stable(active_config) && $stable(pready) && $stable(output_drive_strength_sel);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  property p_err; pready |-> pslverr == !(paddr inside {8'h10, 8'h14, 8'h18}); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("prdata not zero");
  property p_drive; s_wr(8'h14) |-> ##2 output_drive_strength_sel == $past(pwdata[6], 2); endproperty
  a_drive: assert property (p_drive) else $error("drive wrong");
  property p_multi; s_wr(8'h14) ##0 pwdata[5:4] == 2'h1 |-> ##2 active_config == 2'h2; endproperty
  a_multi: assert property (p_multi) else $error("multichip wrong");
  property p_manual;
    s_wr(8'h10) ##0 c2 == 2'h0 |-> ##2 active_config == {1'b0, $past(pwdata[1], 2)}
      && active_data_delay == !$past(pwdata[2], 2);
  endproperty
  a_manual: assert property (p_manual) else $error("manual config wrong");
  property p_auto; c2[1] && $past(c2[1], 2) |-> active_data_delay; endproperty
  a_auto: assert property (p_auto) else $error("auto delay wrong");
  property p_reset; $fell(rst) |-> active_config == 2'h0 && active_data_delay && !output_drive_strength_sel; endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");
endmodule // safd_props
`default_nettype wire

// file: safd_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host audio master
// ****
module safd_host (
  input wire logic [1:0] style,
  output logic bit_clock_pin,
  output logic frame_sync_pin
);
  logic bclk = 1'b0;
  logic sync = 1'b0;
  int n = 0;
  // Style 3 stops the clock; sync moves on falling edges so rising edges see it steady
  always begin
    #100;
    if (style != 2'h3) begin
      bclk = ~bclk;
      if (!bclk) begin
        n = (n + 1) % 64;
        sync = (style == 2'h0) ? (n == 0) : (n < 32);
      end
    end
  end
  // Style 2 crosses the two wires
  assign bit_clock_pin = (style == 2'h2) ? sync : bclk;
  assign frame_sync_pin = (style == 2'h2) ? bclk : sync;
endmodule // safd_host
`default_nettype wire

// file: safd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module safd_top_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] style = 2'h3;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bclk;
  logic fs;
  logic drv;
  logic [1:0] cfg;
  logic dly;
  logic lft;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int n_tests = 0;
  always #12.5 clock = ~clock;
  safd_top safd_top_inst (.clock(clock), .rst(rst), .clock_enable(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clock_pin(bclk), .frame_sync_pin(fs), .output_drive_strength_sel(drv), .active_config(cfg),
    .active_data_delay(dly), .active_left_high(lft));
  safd_host safd_host_inst (.style(style), .bit_clock_pin(bclk), .frame_sync_pin(fs));
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      err_count++;
      close_out();
    end
  endtask
  function automatic logic [1:0] exp_cfg(input logic [31:0] c2, input logic [31:0] c1, input logic [1:0] s);
    if (c2[5]) return (s == 2'h2) ? 2'h0 : (s == 2'h0) ? 2'h1 : 2'h2;
    return c2[4] ? 2'h2 : {1'b0, c1[1]};
  endfunction
  // Reset, map, random manual setups, then each wiring under auto detection
  initial begin
    logic [31:0] a;
    logic [31:0] b;
    int i;
    int k;
    a = $urandom(95584);
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    apb(0, 8'h14, 0);
    chk("ctrl2 reset", rd, 32'h08);
    apb(0, 8'h10, 0);
    chk("ctrl1 reset", rd, 32'h0);
    chk("delay reset", dly, 1);
    apb(1, 8'h1c, 32'hff);
    chk("unmapped err", er, 1);
    $display("test reset_map done");
    for (i = 0; i < 10; i++) begin
      a = (i == 0) ? 32'h10 : $urandom & 32'h5f;
      b = (i == 0) ? 32'h0 : $urandom;
      apb(1, 8'h14, a);
      apb(1, 8'h10, b);
      apb(0, 8'h10, 0);
      chk("ctrl1 back", rd, b & 32'h0e);
      apb(0, 8'h14, 0);
      chk("ctrl2 back", rd, a);
      chk("drive", drv, a[6]);
      chk("config", cfg, exp_cfg(a, b, 0));
      chk("delay", dly, !b[2]);
      if (!a[4]) chk("left", lft, b[3]);
    end
    $display("test manual done");
    for (i = 0; i < 3; i++) begin
      // Mode and format ask for TDM and left justified; auto mode must ignore both
      b = $urandom | 32'h6;
      apb(1, 8'h10, b);
      apb(1, 8'h14, 32'h20);
      style <= i[1:0];
      // Let the auto enable reach the outputs before looking
      repeat (3) @(posedge clock);
      for (k = 0; k < 6000 && cfg !== exp_cfg(32'h20, b, i[1:0]); k++) @(posedge clock);
      chk("auto config", cfg, exp_cfg(32'h20, b, i[1:0]));
      chk("auto delay", dly, 1);
      chk("auto left", lft, (i == 1) ? 1'b1 : b[3]);
      apb(0, 8'h18, 0);
      chk("status", rd, {28'h0, exp_cfg(32'h20, b, i[1:0]), exp_cfg(32'h20, b, i[1:0])});
      if (k == 6000) close_out();
    end
    $display("test auto done");
    // A frozen block must not follow the host until the enable returns
    ce <= 1'b0;
    style <= 2'h0;
    repeat (3000) @(posedge clock);
    chk("freeze", cfg, 2'h0);
    ce <= 1'b1;
    for (k = 0; k < 6000 && cfg !== 2'h1; k++) @(posedge clock);
    chk("thaw", cfg, 2'h1);
    $display("test freeze done");
    close_out();
  end
endmodule // safd_top_tb
bind safd_top safd_props safd_props_inst (.clock(clock), .rst(rst), .clock_enable(clock_enable), .psel(psel),
  .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .output_drive_strength_sel(output_drive_strength_sel), .active_config(active_config),
  .active_data_delay(active_data_delay), .active_left_high(active_left_high));
`default_nettype wire
